// *** shared/fsv_pkg.sv ***
`default_nettype none

package fsv_pkg;

    // Register byte offsets on the APB slave
    localparam logic [7:0] FSV_DIV_OFS = 8'h00;
    localparam logic [7:0] FSV_OPT_OFS = 8'h04;
    localparam logic [7:0] FSV_CFG_OFS = 8'h08;
    localparam logic [7:0] FSV_PROT_OFS = 8'h0c;
    localparam logic [7:0] FSV_STAT_OFS = 8'h10;
    localparam logic [7:0] FSV_CMD_OFS = 8'h14;
    localparam logic [7:0] FSV_KIDX_OFS = 8'h18;
    localparam logic [7:0] FSV_SEC_OFS = 8'h1c;
    localparam logic [7:0] FSV_VBASE_OFS = 8'h20;

    // Nonvolatile locations in the CPU address map
    localparam logic [15:0] FSV_NV_PROT_ADDR = 16'hffbd;
    localparam logic [15:0] FSV_NV_OPT_ADDR = 16'hffbf;
    localparam logic [15:0] FSV_KEY_BASE = 16'hffb0;
    localparam logic [15:0] FSV_FLASH_START = 16'h8000;
    localparam logic [15:0] FSV_VEC_LO = 16'hffc0;
    localparam logic [15:0] FSV_VEC_HI = 16'hfffd;

    // Options byte fields
    localparam int FSV_OPT_BACKDOOR_KEY_ENABLE = 7;
    localparam int FSV_OPT_NORED = 6;
    localparam logic [1:0] FSV_SEC_OPEN = 2'h2;
    localparam logic [7:0] FSV_OPT_USED = 8'hc3;

    // Protection byte fields
    localparam int FSV_PROT_DIS = 0;

    // Config register fields
    localparam int FSV_CFG_KEY_ACCESS_MODE = 5;
    localparam int FSV_CFG_DBGREQ = 0;
    localparam logic [7:0] FSV_CFG_USED = 8'h21;

    // Divider register: bit 7 marks a completed write
    localparam int FSV_DIV_LD = 7;

    // Reset values
    localparam logic [7:0] FSV_RST_BYTE = 8'h00;
    localparam logic [3:0] FSV_KEY_LEN = 4'h8;
    // Load phase cycles spent filling the pin synchroniser
    localparam logic [1:0] FSV_LOAD_WAIT = 2'h2;

    typedef enum logic [0:0] {FSV_LOAD, FSV_RUN} fsv_phase_t;

endpackage : fsv_pkg

`default_nettype wire

// *** core/fsv_guard.sv ***
// Behaviour
// - Reset and interrupt vectors are write protected whenever any block protection is on.
// - Redirection enabled only when the redirect-disable option bit is zero.
// - Redirection needs protection covering part, not all, of the flash.
// - Interrupt vectors FFC0-FFFD are redirected; the reset vector never is.
// - Redirected vector comes from same offset just below the protected region.
// - While secure, unsecured-code or debug accesses to flash/RAM are blocked.
// - Code running from secure memory always keeps normal access.
// - Security field means unsecured only for 1:0; all else secured.
// - Every reset copies the used bits (mask C3) of the nonvolatile options byte into the working options.
// - Debug module refused while secure; background mode only via pin at reset.
// - Key-enable bit zero disables the backdoor unlock entirely.
// - In key-access mode, key location writes are captured, never start commands.
// - Clearing key access with a full match forces the field to 1:0.
// - Key bytes are accepted only from code running in secure memory.
// - Working protection accepts writes only from background debug commands.
// - A passed whole-flash blank check disengages security until reset.
// - Key and nonvolatile bytes share the protected top block with the vectors.
// - Nine 8-bit registers; two loaded at reset from nonvolatile bytes.
// - Leaving reset loads working protection from the nonvolatile protection byte.
// - Last unprotected address is the seven size bits followed by ones.
// - Block protection is on only when the protection-disable bit is zero.
//
// Implementation choice: the APB register port.
`default_nettype none

module fsv_guard
    import fsv_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic apb_bdm_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    // Nonvolatile contents from flash
    input wire logic [7:0] nv_options_byte_i,
    input wire logic [7:0] nv_protection_byte_i,
    input wire logic [63:0] nv_key_i,
    // Flash sequencer results
    input wire logic blank_pass_i,
    // Pin
    input wire logic background_mode_pin_i,
    // CPU and debug accesses
    input wire logic acc_req_i,
    input wire logic [15:0] acc_addr_i,
    input wire logic acc_we_i,
    input wire logic [7:0] acc_wdata_i,
    input wire logic acc_vec_i,
    input wire logic acc_tgt_secure_i,
    input wire logic acc_src_secure_i,
    input wire logic acc_src_bdm_i,
    input wire logic [7:0] mem_rdata_i,
    // Memory side
    output logic mem_req_o,
    output logic [15:0] mem_addr_o,
    output logic mem_we_o,
    output logic [7:0] mem_wdata_o,
    output logic acc_rvalid_o,
    output logic [7:0] acc_rdata_o,
    output logic acc_blocked_o,
    // Status
    output logic secure_o,
    output logic redirect_active_o,
    output logic debug_enable_o,
    output logic active_background_o
);

    ////////////////////////////////////////////////////////////////////////
    // Usage notes
    //
    // One access is taken per cycle and answered two cycles later, so the
    // requester needs no ready of its own.
    //
    // Accesses in the load phase get no answer; register writes there are
    // acknowledged but ignored.
    //
    // A wrong key byte spoils the attempt at once, yet the verdict waits
    // until key access is switched off.
    //
    // Blank pass and key unlock only ever open the field; a reset reloads it from the options byte.
    //
    // The key copy is re-registered every cycle: 64 flops buy a compare path
    // clear of the flash key bus.

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        // Load sequencing and pin synchroniser
        fsv_phase_t phase;
        logic [1:0] ldc;
        logic bkgd_s1;
        logic bkgd_s2;
        // Working registers
        logic [7:0] div;
        logic [7:0] opt;
        logic [7:0] cfg;
        logic [7:0] prot;
        logic [7:0] cmd;
        // Key attempt
        logic [63:0] key;
        logic [3:0] kidx;
        logic kbad;
        // APB answer
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        // Memory request
        logic mem_req;
        logic [15:0] mem_addr;
        logic mem_we;
        logic [7:0] mem_wdata;
        // Read answer
        logic rd_pend;
        logic rd_blk;
        logic rvalid;
        logic [7:0] rdata;
        logic blocked;
        // Status levels
        logic secure;
        logic redir;
        logic dbg_en;
        logic act_bgnd;
    } fsv_state_t;

    fsv_state_t s_q;
    fsv_state_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // Derived protection and security terms

    logic secure;
    logic prot_on;
    logic [15:0] last_unprot;
    logic redir_on;
    logic is_vec;
    logic key_hit;
    logic prot_hit;
    logic blk;
    logic [7:0] rd_byte;
    logic [7:0] key_byte;
    logic apb_acc;
    logic apb_wr;

    // Field decode shared by the access path and the register file
    always_comb begin
        // Security and protection fields
        secure = (s_q.opt[1:0] != FSV_SEC_OPEN);
        prot_on = ~s_q.prot[FSV_PROT_DIS];
        last_unprot = {s_q.prot[7:1], 9'h1ff};
        // Top block holds vectors, key and nonvolatile bytes, all protected together
        redir_on = ~s_q.opt[FSV_OPT_NORED] & prot_on
            & (last_unprot >= FSV_FLASH_START);

        // Classify the current access
        is_vec = acc_vec_i & (acc_addr_i >= FSV_VEC_LO) & (acc_addr_i <= FSV_VEC_HI);
        key_hit = (acc_addr_i[15:3] == FSV_KEY_BASE[15:3]);
        prot_hit = prot_on & acc_tgt_secure_i & (acc_addr_i > last_unprot);
        blk = secure & acc_tgt_secure_i & (~acc_src_secure_i | acc_src_bdm_i);
        key_byte = s_q.key[{s_q.kidx[2:0], 3'h0} +: 8];

        // Request is taken in the first access cycle, while pready is low;
        // a write lands only on the edge that sees pready high
        apb_acc = psel_i & penable_i & ~s_q.pready;
        apb_wr = psel_i & penable_i & s_q.pready & pwrite_i;

        // Read mux; unmapped offsets read as zero
        unique case (paddr_i)
            FSV_DIV_OFS: rd_byte = s_q.div;
            FSV_OPT_OFS: rd_byte = s_q.opt;
            FSV_CFG_OFS: rd_byte = s_q.cfg;
            FSV_PROT_OFS: rd_byte = s_q.prot;
            FSV_STAT_OFS: rd_byte = {3'h0, s_q.act_bgnd, s_q.dbg_en, prot_on, redir_on, secure};
            FSV_CMD_OFS: rd_byte = s_q.cmd;
            FSV_KIDX_OFS: rd_byte = {3'h0, s_q.kbad, s_q.kidx};
            FSV_SEC_OFS: rd_byte = {6'h00, s_q.opt[1:0]};
            FSV_VBASE_OFS: rd_byte = last_unprot[15:8];
            default: rd_byte = FSV_RST_BYTE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    // Load phase lasts until the pin synchroniser has filled, so the nonvolatile
    // bytes and the pin are caught by a clocked process, not by the reset
    always_comb begin
        s_d = s_q;

        // Pulses fall back low each cycle; levels carry over
        s_d.bkgd_s1 = background_mode_pin_i;
        s_d.bkgd_s2 = s_q.bkgd_s1;
        s_d.pready = apb_acc;
        s_d.pslverr = 1'b0;
        s_d.mem_req = 1'b0;
        s_d.mem_we = 1'b0;
        s_d.rvalid = s_q.rd_pend;
        s_d.rd_pend = 1'b0;
        s_d.blocked = 1'b0;

        // Load once after reset, then run
        unique case (s_q.phase)
            FSV_LOAD: begin
                // Reset clears the synchroniser, so capture waits until the
                // pin has passed both stages; else a high pin reads as low
                s_d.ldc = s_q.ldc + 2'h1;
                if (s_q.ldc == FSV_LOAD_WAIT) begin
                    s_d.opt = nv_options_byte_i & FSV_OPT_USED;
                    s_d.prot = nv_protection_byte_i;
                    s_d.act_bgnd = ~s_q.bkgd_s2;
                    s_d.phase = FSV_RUN;
                end
            end
            FSV_RUN: begin
                // Registered read data; blocked reads give zero
                if (s_q.rd_pend) begin
                    s_d.rdata = s_q.rd_blk ? FSV_RST_BYTE : mem_rdata_i;
                end

                // CPU and debug access path
                if (acc_req_i) begin
                    s_d.mem_addr = acc_addr_i;
                    s_d.mem_wdata = acc_wdata_i;
                    if (is_vec && redir_on && !acc_we_i) begin
                        s_d.mem_addr = {last_unprot[15:6], acc_addr_i[5:0]};
                    end
                    // Writes: key capture, refusal or pass-through
                    if (acc_we_i) begin
                        if (s_q.cfg[FSV_CFG_KEY_ACCESS_MODE] && key_hit) begin
                            // Captured as compare value, never a program step
                            s_d.mem_req = 1'b0;
                            if (acc_src_secure_i && !acc_src_bdm_i) begin
                                if (s_q.kidx < FSV_KEY_LEN) begin
                                    s_d.kidx = s_q.kidx + 4'h1;
                                    // Out of order bytes spoil the attempt
                                    if (acc_addr_i[2:0] != s_q.kidx[2:0] ||
                                        acc_wdata_i != key_byte) begin
                                        s_d.kbad = 1'b1;
                                    end
                                end
                            end else begin
                                // Debug or untrusted key bytes never count
                                s_d.blocked = blk;
                            end
                        end else if (blk || prot_hit) begin
                            s_d.blocked = 1'b1;
                        end else begin
                            s_d.mem_req = 1'b1;
                            s_d.mem_we = 1'b1;
                        end
                    end else begin
                        s_d.mem_req = ~blk;
                        s_d.blocked = blk;
                        s_d.rd_pend = 1'b1;
                        s_d.rd_blk = blk;
                    end
                end

                // Blank check pass removes security until next reset
                if (blank_pass_i) begin
                    s_d.opt[1:0] = FSV_SEC_OPEN;
                end

                // APB register writes, landing on the edge that sees pready high
                if (apb_wr) begin
                    unique case (paddr_i)
                        FSV_DIV_OFS: begin
                            // Write once; later writes ignored
                            if (!s_q.div[FSV_DIV_LD]) begin
                                s_d.div = {1'b1, pwdata_i[6:0]};
                            end
                        end
                        FSV_CFG_OFS: begin
                            s_d.cfg = pwdata_i[7:0] & FSV_CFG_USED;
                            if (pwdata_i[FSV_CFG_KEY_ACCESS_MODE] && !s_q.cfg[FSV_CFG_KEY_ACCESS_MODE]) begin
                                s_d.kidx = 4'h0;
                                s_d.kbad = 1'b0;
                            end
                            // Falling key access judges the collected key
                            if (!pwdata_i[FSV_CFG_KEY_ACCESS_MODE] && s_q.cfg[FSV_CFG_KEY_ACCESS_MODE] &&
                                s_q.opt[FSV_OPT_BACKDOOR_KEY_ENABLE] &&
                                s_q.kidx == FSV_KEY_LEN && !s_q.kbad) begin
                                s_d.opt[1:0] = FSV_SEC_OPEN;
                            end // mismatch leaves opt untouched
                        end
                        FSV_PROT_OFS: begin
                            if (apb_bdm_i) begin
                                s_d.prot = pwdata_i[7:0];
                            end
                        end
                        FSV_CMD_OFS: s_d.cmd = pwdata_i[7:0];
                        FSV_OPT_OFS, FSV_STAT_OFS, FSV_KIDX_OFS, FSV_SEC_OFS,
                        FSV_VBASE_OFS: s_d.cmd = s_q.cmd; // Read-only, write ignored
                        default: s_d.cmd = s_q.cmd; // Error already given with pready
                    endcase
                end
            end
        endcase

        // Bad offsets are flagged as the request is taken, so the error
        // stands with pready for writes as well as reads
        if (apb_acc) begin
            s_d.pslverr = (paddr_i > FSV_VBASE_OFS) || (paddr_i[1:0] != 2'h0);
        end

        // Read data is registered here and stands with pready
        if (apb_acc && !pwrite_i) begin
            s_d.prdata = {24'h000000, rd_byte};
        end

        // Copy of the stored key from flash, re-registered every cycle for the compare
        s_d.key = nv_key_i;

        // Status outputs follow the updated working registers
        s_d.secure = (s_d.opt[1:0] != FSV_SEC_OPEN);
        s_d.redir = ~s_d.opt[FSV_OPT_NORED] & ~s_d.prot[FSV_PROT_DIS]
            & ({s_d.prot[7:1], 9'h1ff} >= FSV_FLASH_START);
        s_d.dbg_en = s_d.cfg[FSV_CFG_DBGREQ] & ~s_d.secure;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    // Only constants under reset; straps are caught in the load phase
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q <= '0;
            s_q.phase <= FSV_LOAD;
            // Closed until the options have been loaded
            s_q.secure <= 1'b1;
            s_q.opt <= FSV_OPT_USED;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flip-flops

    // APB answer
    assign pready_o = s_q.pready;
    assign prdata_o = s_q.prdata;
    assign pslverr_o = s_q.pslverr;

    // Memory request
    assign mem_req_o = s_q.mem_req;
    assign mem_addr_o = s_q.mem_addr;
    assign mem_we_o = s_q.mem_we;
    assign mem_wdata_o = s_q.mem_wdata;

    // Read answer
    assign acc_rvalid_o = s_q.rvalid;
    assign acc_rdata_o = s_q.rdata;
    assign acc_blocked_o = s_q.blocked;

    // Status levels
    assign secure_o = s_q.secure;
    assign redirect_active_o = s_q.redir;
    assign debug_enable_o = s_q.dbg_en;
    assign active_background_o = s_q.act_bgnd;

endmodule // fsv_guard

`default_nettype wire

// *** test/fsv_guard_chk.sv ***
`default_nettype none

module fsv_guard_chk
    import fsv_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Access requests
    input wire logic acc_req_i,
    input wire logic [15:0] acc_addr_i,
    input wire logic acc_we_i,
    input wire logic acc_vec_i,
    input wire logic acc_tgt_secure_i,
    input wire logic acc_src_secure_i,
    input wire logic acc_src_bdm_i,
    input wire logic [7:0] mem_rdata_i,
    input wire logic blank_pass_i,
    // Design outputs
    input wire logic mem_req_o,
    input wire logic [15:0] mem_addr_o,
    input wire logic acc_rvalid_o,
    input wire logic [7:0] acc_rdata_o,
    input wire logic acc_blocked_o,
    input wire logic secure_o,
    input wire logic redirect_active_o,
    input wire logic debug_enable_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    // Reads from trusted code, which no security state may refuse
    logic trd;
    assign trd = acc_req_i && !acc_we_i && acc_src_secure_i && !acc_src_bdm_i;

    ////////////////////////////////////////////////////////////////////////////
    property p_blk; acc_req_i && acc_tgt_secure_i && secure_o
        && (!acc_src_secure_i || acc_src_bdm_i) |=> acc_blocked_o && !mem_req_o; endproperty
    a_blk: assert property (p_blk) else $error("untrusted access not blocked");
    property p_zero; acc_blocked_o && !$past(acc_we_i) |=> acc_rvalid_o
        && acc_rdata_o == 8'h00; endproperty
    a_zero: assert property (p_zero) else $error("blocked read not zero");
    property p_trust; trd |=> mem_req_o ##1 acc_rvalid_o
        && acc_rdata_o == $past(mem_rdata_i); endproperty
    a_trust: assert property (p_trust) else $error("trusted read refused");
    property p_rstv; trd && acc_vec_i && acc_addr_i[15:1] == 15'h7fff
        |=> mem_addr_o == $past(acc_addr_i); endproperty
    a_rstv: assert property (p_rstv) else $error("reset vector moved");
    property p_redir; trd && acc_vec_i && redirect_active_o
        && acc_addr_i inside {[FSV_VEC_LO:FSV_VEC_HI]} |=> mem_addr_o[15:9] != 7'h7f
        && mem_addr_o[8:0] == {3'h7, $past(acc_addr_i[5:0])}; endproperty
    a_redir: assert property (p_redir) else $error("vector not redirected");
    property p_nored; trd && acc_vec_i && !redirect_active_o
        |=> mem_addr_o == $past(acc_addr_i); endproperty
    a_nored: assert property (p_nored) else $error("vector moved without redirect");
    property p_dbg; secure_o |-> !debug_enable_o; endproperty
    a_dbg: assert property (p_dbg) else $error("debug enabled while secure");
    property p_blank; blank_pass_i |=> !secure_o; endproperty
    a_blank: assert property (p_blank) else $error("blank pass kept security");
endmodule // fsv_guard_chk

bind fsv_guard fsv_guard_chk i_chk (.clk_i, .arst_n_i, .acc_req_i, .acc_addr_i, .acc_we_i,
    .acc_vec_i, .acc_tgt_secure_i, .acc_src_secure_i, .acc_src_bdm_i, .mem_rdata_i,
    .blank_pass_i, .mem_req_o, .mem_addr_o, .acc_rvalid_o, .acc_rdata_o, .acc_blocked_o,
    .secure_o, .redirect_active_o, .debug_enable_o);

`default_nettype wire

// *** test/fsv_mem_model.sv ***
`default_nettype none

module fsv_mem_model #(
    parameter logic [63:0] KEY = 64'h0123456789abcdef
) (
    // Request from the guard
    input wire logic mem_req_i,
    input wire logic [15:0] mem_addr_i,
    // Answers
    output logic [7:0] mem_rdata_o,
    output logic [63:0] nv_key_o
);
    // Cells hold a hash of their address; unselected bus shows the inverse
    assign mem_rdata_o = mem_req_i ? (mem_addr_i[15:8] ^ mem_addr_i[7:0] ^ 8'h3c)
        : ~(mem_addr_i[15:8] ^ mem_addr_i[7:0] ^ 8'h3c);
    // Stored key lives in the top protected block
    assign nv_key_o = KEY;
endmodule // fsv_mem_model

`default_nettype wire

// *** test/fsv_guard_bench.sv ***
`default_nettype none

module fsv_guard_bench
    import fsv_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [63:0] KEY = 64'h0123456789abcdef;
    logic clk_i = 1'h0, arst_n_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
    logic apb_bdm_i = 1'h0, blank_pass_i = 1'h0, background_mode_pin_i = 1'h1;
    logic acc_req_i = 1'h0, acc_we_i = 1'h0, acc_vec_i = 1'h0, acc_tgt_secure_i = 1'h1;
    logic acc_src_secure_i = 1'h0, acc_src_bdm_i = 1'h0;
    logic [7:0] paddr_i = 8'h00, nv_options_byte_i = 8'h00, nv_protection_byte_i = 8'h00;
    logic [7:0] acc_wdata_i = 8'h00, mem_rdata_i, acc_rdata_o, mem_wdata_o, ad;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic [15:0] acc_addr_i = 16'h0, mem_addr_o, ma;
    logic [63:0] nv_key_i;
    logic pready_o, pslverr_o, mem_req_o, mem_we_o, acc_rvalid_o, acc_blocked_o, secure_o;
    logic redirect_active_o, debug_enable_o, active_background_o, perr, mr, blk;
    logic [8:0] wr;
    int err_count = 0, compares = 0, cyc = 0;

    fsv_guard i_dut (.clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .apb_bdm_i, .pready_o, .prdata_o, .pslverr_o, .nv_options_byte_i, .nv_protection_byte_i,
        .nv_key_i, .blank_pass_i, .background_mode_pin_i, .acc_req_i, .acc_addr_i, .acc_we_i,
        .acc_wdata_i, .acc_vec_i, .acc_tgt_secure_i, .acc_src_secure_i, .acc_src_bdm_i,
        .mem_rdata_i, .mem_req_o, .mem_addr_o, .mem_we_o, .mem_wdata_o, .acc_rvalid_o,
        .acc_rdata_o, .acc_blocked_o, .secure_o, .redirect_active_o, .debug_enable_o,
        .active_background_o);
    fsv_mem_model #(.KEY(KEY)) i_mem (.mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o),
        .mem_rdata_o(mem_rdata_i), .nv_key_o(nv_key_i));

    ////////////////////////////////////////////////////////////////////////////
    // Clock, and a ceiling far above the run length to cut hangs
    initial forever #4 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_count++;
            conclude();
        end
    end

    task automatic conclude;
        if (err_count == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] e, input logic [31:0] s, input string n);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    // Options are only sampled at reset, so every setup needs a full reset
    task automatic rst(input logic [7:0] o, input logic [7:0] p, input logic pin);
        @(posedge clk_i);
        arst_n_i <= 1'h0;
        nv_options_byte_i <= o;
        nv_protection_byte_i <= p;
        background_mode_pin_i <= pin;
        repeat (16) @(posedge clk_i);
        arst_n_i <= 1'h1;
        repeat (5) @(posedge clk_i);
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic b);
        @(posedge clk_i);
        psel_i <= 1'h1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= {24'h0, d};
        apb_bdm_i <= b;
        @(posedge clk_i);
        penable_i <= 1'h1;
        do @(posedge clk_i); while (pready_o !== 1'h1);
        rd = prdata_o;
        perr = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
    endtask

    // Fixed spacing of the access path; also keeps key writes apart
    task automatic acc(input logic [15:0] a, input logic w, v, ss, b, input logic [7:0] d);
        @(posedge clk_i);
        acc_req_i <= 1'h1;
        acc_addr_i <= a;
        acc_we_i <= w;
        acc_vec_i <= v;
        acc_src_secure_i <= ss;
        acc_src_bdm_i <= b;
        acc_wdata_i <= d;
        @(posedge clk_i);
        acc_req_i <= 1'h0;
        @(posedge clk_i);
        mr = mem_req_o;
        ma = mem_addr_o;
        blk = acc_blocked_o;
        wr = {mem_we_o, mem_wdata_o};
        @(posedge clk_i);
        ad = acc_rdata_o;
    endtask

    task automatic key(input logic [63:0] k, input logic b);
        apb(1'h1, FSV_CFG_OFS, 8'h20, 1'h0);
        for (int i = 0; i < 8; i++) begin
            acc(FSV_KEY_BASE + 16'(i), 1'h1, 1'h0, !b, b, k[8*i+:8]);
            chk(1'h0, mr, "key write to memory");
        end
        apb(1'h1, FSV_CFG_OFS, 8'h00, 1'h0);
        repeat (2) @(posedge clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rst(8'hbf, 8'hfc, 1'h1);
        apb(1'h0, FSV_OPT_OFS, 8'h00, 1'h0);
        chk(32'h83, rd, "options");
        apb(1'h0, FSV_VBASE_OFS, 8'h00, 1'h0);
        chk(32'hfd, rd, "last unprotected");
        apb(1'h1, FSV_PROT_OFS, 8'h01, 1'h0);
        apb(1'h0, FSV_PROT_OFS, 8'h00, 1'h0);
        chk(32'hfc, rd, "protection by app");
        apb(1'h1, FSV_PROT_OFS, 8'h01, 1'h1);
        apb(1'h0, FSV_PROT_OFS, 8'h00, 1'h0);
        chk(32'h01, rd, "protection by debug");
        apb(1'h0, 8'h24, 8'h00, 1'h0);
        chk(1'h1, perr, "unmapped error");
    endtask

    task automatic t_sec;
        for (int p = 0; p < 4; p++) begin
            rst({6'h20, 2'(p)}, 8'hff, 1'h1);
            chk(p != 2, secure_o, "security field");
        end
    endtask

    task automatic t_redir;
        rst(8'h83, 8'hfc, 1'h1);
        chk(1'h1, redirect_active_o, "redirect partial");
        chk(1'h0, active_background_o, "background, pin high");
        acc(16'hffc0, 1'h0, 1'h1, 1'h1, 1'h0, 8'h00);
        chk(16'hfdc0, ma, "first vector");
        acc(16'hfffd, 1'h0, 1'h1, 1'h1, 1'h0, 8'h00);
        chk(16'hfdfd, ma, "last vector");
        acc(16'hfffe, 1'h0, 1'h1, 1'h1, 1'h0, 8'h00);
        chk(16'hfffe, ma, "reset vector");
        acc(16'hffe0, 1'h1, 1'h0, 1'h1, 1'h0, 8'h55);
        chk(1'h1, blk, "vector write");
        rst(8'h83, 8'h01, 1'h1);
        chk(1'h0, redirect_active_o, "redirect, no protection");
        rst(8'h83, 8'h7e, 1'h1);
        chk(1'h0, redirect_active_o, "redirect, all protected");
        rst(8'hc3, 8'hfc, 1'h1);
        chk(1'h0, redirect_active_o, "redirect disabled");
        acc(16'hffe0, 1'h0, 1'h1, 1'h1, 1'h0, 8'h00);
        chk(16'hffe0, ma, "vector not moved");
    endtask

    task automatic t_block;
        rst(8'h83, 8'hff, 1'h0);
        chk(1'h1, active_background_o, "background, pin low");
        acc(16'h8123, 1'h0, 1'h0, 1'h0, 1'h0, 8'h00);
        chk(1'h1, blk, "unsecured read");
        chk(8'h00, ad, "unsecured data");
        acc(16'h8123, 1'h0, 1'h0, 1'h1, 1'h1, 8'h00);
        chk(1'h1, blk, "debug read");
        acc(16'h8123, 1'h0, 1'h0, 1'h1, 1'h0, 8'h00);
        chk(8'h81 ^ 8'h23 ^ 8'h3c, ad, "secure read");
        acc(16'h8124, 1'h1, 1'h0, 1'h1, 1'h0, 8'h5a);
        chk(9'h15a, wr, "secure write");
        apb(1'h1, FSV_CFG_OFS, 8'h01, 1'h1);
        repeat (2) @(posedge clk_i);
        chk(1'h0, debug_enable_o, "debug while secure");
        blank_pass_i <= 1'h1;
        @(posedge clk_i);
        blank_pass_i <= 1'h0;
        @(posedge clk_i);
        chk(1'h0, secure_o, "blank pass");
        chk(1'h1, debug_enable_o, "debug once open");
        rst(8'h83, 8'hff, 1'h1);
        chk(1'h1, secure_o, "secure after reset");
        rst(8'h82, 8'hff, 1'h1);
        chk(1'h0, secure_o, "field kept open");
    endtask

    task automatic t_key;
        rst(8'h83, 8'hff, 1'h1);
        key(KEY ^ 64'h1, 1'h0);
        chk(1'h1, secure_o, "wrong key");
        key(KEY, 1'h1);
        chk(1'h1, secure_o, "key by debug");
        key(KEY, 1'h0);
        chk(1'h0, secure_o, "right key");
        acc(16'h8123, 1'h0, 1'h0, 1'h0, 1'h0, 8'h00);
        chk(1'h0, blk, "read after unlock");
        rst(8'h03, 8'hff, 1'h1);
        key(KEY, 1'h0);
        chk(1'h1, secure_o, "key disabled");
    endtask

    initial begin
        t_regs();
        t_sec();
        t_redir();
        t_block();
        t_key();
        conclude();
    end
endmodule // fsv_guard_bench

`default_nettype wire
